// ---- bench/tb.sv ----
// Self-checking bench of the PWM timing unit
`timescale 1ns/1ps
`include "tpwm_cfg.svh"

module tb;
	import tpwm_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys, reset, pready, pslverr, period_sync_pulse, sync_irq;
	logic sync_q, err;
	tpwm_apb_req_s req;
	tpwm_drive_s drive;
	logic [31:0] prdata, rd, s1;
	logic [15:0] nsync, per_last, wid_last, overlap;
	logic [2:0][15:0] up_on, lo_on;
	int errors, total_checks, cyc;

	tpwm_top tpwm_top_i (.clk_sys(clk_sys), .reset(reset), .apb_req(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive),
		.period_sync_pulse(period_sync_pulse), .sync_irq(sync_irq));
	tpwm_gate_model tpwm_gate_model_i (.clk_sys(clk_sys), .reset(reset),
		.drive(drive), .period_sync_pulse(period_sync_pulse), .nsync(nsync),
		.per_last(per_last), .wid_last(wid_last), .overlap(overlap),
		.up_on(up_on), .lo_on(lo_on));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (e !== g) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Request held until pready is seen at a rising edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		@(posedge clk_sys);
		// Unbounded: without pready only the bench timeout ends this wait
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	// Bounded wait for a number of sync rises
	task wait_sync(input int n);
		int k;
		logic [15:0] s;
		s = nsync;
		k = 0;
		while (nsync !== s + 16'(n) && k < 5000) begin
			@(posedge clk_sys);
			k++;
		end
		chk("sync arrival", 32'h0, 32'(k >= 5000));
	endtask

	// Irq pulse must coincide with every sync rise
	always @(posedge clk_sys) begin
		sync_q <= period_sync_pulse;
		if (!reset && (sync_irq || (period_sync_pulse && !sync_q)))
			chk("sync_irq", 32'(period_sync_pulse & ~sync_q), 32'(sync_irq));
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 12000) begin
			errors++;
			end_sim;
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		xfer(0, `TPWM_OFS_SYNC_WIDTH, 0);
		chk("sync width reset", 32'h27, rd);
		xfer(0, `TPWM_OFS_MODE, 0);
		chk("mode reset", 32'h0, rd & 32'h40);
		xfer(1, `TPWM_OFS_DEAD_TIME, 32'hfff);
		xfer(0, `TPWM_OFS_DEAD_TIME, 0);
		chk("dead time width", 32'h3ff, rd);
		xfer(0, 8'h40, 0);
		chk("unmapped error", 32'h1, 32'(err));
		xfer(1, `TPWM_OFS_DEAD_TIME, 32'h5);
		xfer(1, `TPWM_OFS_SYNC_WIDTH, 32'h9);
		$display("test regs done");
	endtask

	task t_start;
		int c;
		xfer(1, `TPWM_OFS_DUTY_A, 32'd30);
		xfer(1, `TPWM_OFS_DUTY_B, 32'd0);
		xfer(1, `TPWM_OFS_DUTY_C, 32'd100);
		repeat (20) @(posedge clk_sys);
		chk("idle syncs", 32'h0, 32'(nsync));
		chk("idle drives", 32'h0, 32'(drive));
		xfer(1, `TPWM_OFS_HALF_PERIOD, 32'd100);
		c = 0;
		while (period_sync_pulse !== 1'b1 && c < 400) begin
			@(posedge clk_sys);
			c++;
		end
		chk("first sync delay", 32'h1, 32'(c >= 147 && c <= 153));
		$display("test start done");
	endtask

	task t_single;
		wait_sync(2);
		chk("period", 32'd200, 32'(per_last));
		chk("sync width", 32'd10, 32'(wid_last));
		chk("a upper", 32'd50, 32'(up_on[0]));
		chk("a lower", 32'd130, 32'(lo_on[0]));
		chk("b upper", 32'd0, 32'(up_on[1]));
		chk("b lower", 32'd190, 32'(lo_on[1]));
		chk("c upper", 32'd190, 32'(up_on[2]));
		chk("c lower", 32'd0, 32'(lo_on[2]));
		xfer(1, `TPWM_OFS_DEAD_TIME, 32'h0);
		wait_sync(2);
		chk("a upper no gap", 32'd60, 32'(up_on[0]));
		chk("a lower no gap", 32'd140, 32'(lo_on[0]));
		$display("test single done");
	endtask

	task t_select;
		xfer(1, `TPWM_OFS_OUT_SEL, 32'h20);
		wait_sync(2);
		chk("a upper off", 32'd0, 32'(up_on[0]));
		chk("a lower kept", 32'd140, 32'(lo_on[0]));
		xfer(1, `TPWM_OFS_OUT_SEL, 32'h100);
		wait_sync(2);
		chk("a upper crossed", 32'd140, 32'(up_on[0]));
		chk("a lower crossed", 32'd60, 32'(lo_on[0]));
		xfer(1, `TPWM_OFS_OUT_SEL, 32'h0);
		$display("test select done");
	endtask

	task t_double;
		xfer(1, `TPWM_OFS_MODE, 32'h40);
		xfer(0, `TPWM_OFS_MODE, 0);
		chk("mode double", 32'h40, rd & 32'h40);
		wait_sync(2);
		chk("half period", 32'd100, 32'(per_last));
		chk("a upper half", 32'd30, 32'(up_on[0]));
		chk("a lower half", 32'd70, 32'(lo_on[0]));
		xfer(0, `TPWM_OFS_STATUS, 0);
		s1 = rd;
		wait_sync(1);
		xfer(0, `TPWM_OFS_STATUS, 0);
		chk("half flag toggles", 32'h1, 32'(s1[3] ^ rd[3]));
		chk("no shoot through", 32'h0, 32'(overlap));
		$display("test double done");
	endtask

	initial begin
		errors = 0;
		total_checks = 0;
		cyc = 0;
		sync_q = 1'b0;
		req = '0;
		reset = 1'b1;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		t_regs();
		t_start();
		t_single();
		t_select();
		t_double();
		end_sim();
	end
endmodule

// ---- bench/tpwm_gate_model.sv ----
// Gate driver side model measuring drive on-times per sync period
`timescale 1ns/1ps

module tpwm_gate_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Observed pins
	input tpwm_pkg::tpwm_drive_s drive,
	input wire logic period_sync_pulse,
	// Sync count, overlap total and measurements of the last full window
	output logic [15:0] nsync,
	output logic [15:0] per_last,
	output logic [15:0] wid_last,
	output logic [15:0] overlap,
	output logic [2:0][15:0] up_on,
	output logic [2:0][15:0] lo_on
);
	import tpwm_pkg::*;

	// ----------------------------------------
	// Window counters
	// ----------------------------------------
	logic sync_q_reg;
	logic sync_qq_reg;
	logic rise_w;
	logic [15:0] per_reg;
	logic [15:0] wid_reg;
	logic [2:0][15:0] up_reg;
	logic [2:0][15:0] lo_reg;

	// Drives lag the sync by one register, so the window opens a clock late
	assign rise_w = sync_q_reg & ~sync_qq_reg;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sync_q_reg <= 1'b0;
			sync_qq_reg <= 1'b0;
			{nsync, per_last, wid_last, overlap} <= '0;
			{per_reg, wid_reg, up_reg, lo_reg, up_on, lo_on} <= '0;
		end else begin
			sync_q_reg <= period_sync_pulse;
			sync_qq_reg <= sync_q_reg;
			overlap <= overlap + 16'(|(drive.upper & drive.lower));
			if (period_sync_pulse & ~sync_q_reg)
				wid_reg <= 16'h1;
			else if (period_sync_pulse)
				wid_reg <= wid_reg + 16'h1;
			if (~period_sync_pulse & sync_q_reg)
				wid_last <= wid_reg;
			if (rise_w) begin
				nsync <= nsync + 16'h1;
				per_last <= per_reg;
				per_reg <= 16'h1;
				for (int i = 0; i < 3; i++) begin
					up_on[i] <= up_reg[i];
					lo_on[i] <= lo_reg[i];
					up_reg[i] <= 16'(drive.upper[i]);
					lo_reg[i] <= 16'(drive.lower[i]);
				end
			end else begin
				per_reg <= per_reg + 16'h1;
				for (int i = 0; i < 3; i++) begin
					up_reg[i] <= up_reg[i] + 16'(drive.upper[i]);
					lo_reg[i] <= lo_reg[i] + 16'(drive.lower[i]);
				end
			end
		end
	end
endmodule

// ---- src/tpwm_cfg.svh ----
// Offsets, field positions, reset values and widths of the PWM timing unit
`ifndef TPWM_CFG_SVH
`define TPWM_CFG_SVH

// ----------------------------------------
// Bus widths
// ----------------------------------------
`define TPWM_ADDR_W 8
`define TPWM_DATA_W 32

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TPWM_OFS_HALF_PERIOD 8'h00
`define TPWM_OFS_DEAD_TIME 8'h04
`define TPWM_OFS_MIN_PULSE 8'h08
`define TPWM_OFS_SYNC_WIDTH 8'h0c
`define TPWM_OFS_DUTY_A 8'h10
`define TPWM_OFS_DUTY_B 8'h14
`define TPWM_OFS_DUTY_C 8'h18
`define TPWM_OFS_OUT_SEL 8'h1c
`define TPWM_OFS_MODE 8'h20
`define TPWM_OFS_STATUS 8'h24

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TPWM_MODE_DOUBLE_BIT 6
`define TPWM_STAT_HALF_BIT 3
`define TPWM_STAT_RUN_BIT 0
`define TPWM_SEG_DIS_BIT 0
`define TPWM_SEG_XOVER_BIT 6
`define TPWM_SYNC_W_RST 8'h27
`define TPWM_SEL_RST 9'h000

`endif

// ---- src/tpwm_pkg.sv ----
// Types shared by the PWM timing unit and its bench
`include "tpwm_cfg.svh"

package tpwm_pkg;

	// ----------------------------------------
	// Bus request carrier
	// ----------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`TPWM_ADDR_W-1:0] paddr;
		logic [`TPWM_DATA_W-1:0] pwdata;
	} tpwm_apb_req_s;

	// ----------------------------------------
	// Gate drive carrier, index 0 is phase a
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] upper;
		logic [2:0] lower;
	} tpwm_drive_s;

	// ----------------------------------------
	// Half of the switching period
	// ----------------------------------------
	typedef enum logic {
		TPWM_HALF_FIRST = 1'b0,
		TPWM_HALF_SECOND = 1'b1
	} tpwm_half_e;

endpackage

// ---- src/tpwm_top.sv ----
// Three-phase center-based PWM timing unit with APB register slave
// Notes on behaviour
// - Each complementary pair gets a dead gap between turn-off and turn-on.
// - Dead gap equals dead-time value times two clock periods.
// - Dead-time register is ten bits wide, up to 0x3ff.
// - Dead-time zero makes complementary edges coincide.
// - Mode bit 6 clear selects single update, set selects double update.
// - Update-mode bit reads clear after reset.
// - Single mode: one sync per period, its rising edge loads all values.
// - Output selection is taken into the output stage at that edge too.
// - Double mode adds a midpoint sync which reloads everything.
// - Status bit 3 is zero in first half, one in second half.
// - Sync stays high sync-width value plus one clocks.
// - Sync-width register resets to 0x27.
// - Sync recurs per period, twice per period in double mode.
// - Duty value sets high-side on-time per half period.
// - Pulses are centered in the period in single mode.
// - Every edge is shifted by dead-time value clock periods.
// - On-times: 2*(duty-dt) high side, 2*(half-duty-dt) low side.
// - On-times are limited to zero through the full period.
// - Double mode on-times and period sum the two half values.
// - Double mode uses the dead time latched for each half.
// - Nothing runs until half-period and three duty registers are written.
// - First sync 1.5 half-periods after start single, one half-period double.
// - Timer counts system clocks, half-period value is clocks per half.
// - Each sync raises an interrupt request pulse.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "tpwm_cfg.svh"

module tpwm_top #(
	parameter int CNT_W = 16,
	parameter int DT_W = 10,
	parameter int SW_W = 8,
	parameter int SEL_W = 9
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register bus
	input tpwm_pkg::tpwm_apb_req_s apb_req,
	output logic [`TPWM_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Gate drives and sync
	output tpwm_pkg::tpwm_drive_s drive,
	output logic period_sync_pulse,
	output logic sync_irq
);
	import tpwm_pkg::*;

	localparam int SW = CNT_W + 2;

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	logic [CNT_W-1:0] half_period_count_reg;
	logic [DT_W-1:0] dead_time_reg;
	logic [CNT_W-1:0] min_pulse_width_reg;
	logic [SW_W-1:0] sync_pulse_width_reg;
	logic [CNT_W-1:0] duty_reg [3];
	logic [SEL_W-1:0] output_selection_reg;
	logic double_mode_reg;
	logic [3:0] written_reg;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic setup_w;
	logic write_w;
	logic hit_next;
	logic [`TPWM_DATA_W-1:0] rdata_next;
	logic hit_reg;
	logic [`TPWM_DATA_W-1:0] prdata_reg;

	// Timing state, declared here for status readback
	logic started_reg;
	tpwm_half_e half_reg;

	assign setup_w = apb_req.psel & ~apb_req.penable;
	assign write_w = apb_req.psel & apb_req.penable & apb_req.pwrite;
	// Always ready: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = apb_req.psel & apb_req.penable & ~hit_reg;
	assign prdata = prdata_reg;

	always_comb begin
		hit_next = 1'b1;
		rdata_next = '0;
		unique case (apb_req.paddr)
			`TPWM_OFS_HALF_PERIOD: rdata_next[CNT_W-1:0] = half_period_count_reg;
			`TPWM_OFS_DEAD_TIME: rdata_next[DT_W-1:0] = dead_time_reg;
			`TPWM_OFS_MIN_PULSE: rdata_next[CNT_W-1:0] = min_pulse_width_reg;
			`TPWM_OFS_SYNC_WIDTH: rdata_next[SW_W-1:0] = sync_pulse_width_reg;
			`TPWM_OFS_DUTY_A: rdata_next[CNT_W-1:0] = duty_reg[0];
			`TPWM_OFS_DUTY_B: rdata_next[CNT_W-1:0] = duty_reg[1];
			`TPWM_OFS_DUTY_C: rdata_next[CNT_W-1:0] = duty_reg[2];
			`TPWM_OFS_OUT_SEL: rdata_next[SEL_W-1:0] = output_selection_reg;
			`TPWM_OFS_MODE: rdata_next[`TPWM_MODE_DOUBLE_BIT] = double_mode_reg;
			`TPWM_OFS_STATUS: begin
				rdata_next[`TPWM_STAT_HALF_BIT] = half_reg;
				rdata_next[`TPWM_STAT_RUN_BIT] = started_reg;
			end
			default: hit_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hit_reg <= 1'b0;
			prdata_reg <= '0;
		end else if (setup_w) begin
			hit_reg <= hit_next;
			prdata_reg <= apb_req.pwrite ? '0 : rdata_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			half_period_count_reg <= '0;
			dead_time_reg <= '0;
			min_pulse_width_reg <= '0;
			sync_pulse_width_reg <= `TPWM_SYNC_W_RST;
			duty_reg[0] <= '0;
			duty_reg[1] <= '0;
			duty_reg[2] <= '0;
			output_selection_reg <= `TPWM_SEL_RST;
			double_mode_reg <= 1'b0;
		end else if (write_w) begin
			unique case (apb_req.paddr)
				`TPWM_OFS_HALF_PERIOD:
					half_period_count_reg <= apb_req.pwdata[CNT_W-1:0];
				`TPWM_OFS_DEAD_TIME:
					dead_time_reg <= apb_req.pwdata[DT_W-1:0];
				`TPWM_OFS_MIN_PULSE:
					min_pulse_width_reg <= apb_req.pwdata[CNT_W-1:0];
				`TPWM_OFS_SYNC_WIDTH:
					sync_pulse_width_reg <= apb_req.pwdata[SW_W-1:0];
				`TPWM_OFS_DUTY_A: duty_reg[0] <= apb_req.pwdata[CNT_W-1:0];
				`TPWM_OFS_DUTY_B: duty_reg[1] <= apb_req.pwdata[CNT_W-1:0];
				`TPWM_OFS_DUTY_C: duty_reg[2] <= apb_req.pwdata[CNT_W-1:0];
				`TPWM_OFS_OUT_SEL:
					output_selection_reg <= apb_req.pwdata[SEL_W-1:0];
				`TPWM_OFS_MODE:
					double_mode_reg <= apb_req.pwdata[`TPWM_MODE_DOUBLE_BIT];
				default: begin
				end
			endcase
		end
	end

	// Marks which of the four start registers have seen a write
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			written_reg <= '0;
		end else if (write_w) begin
			unique case (apb_req.paddr)
				`TPWM_OFS_DUTY_A: written_reg[0] <= 1'b1;
				`TPWM_OFS_DUTY_B: written_reg[1] <= 1'b1;
				`TPWM_OFS_DUTY_C: written_reg[2] <= 1'b1;
				`TPWM_OFS_HALF_PERIOD: written_reg[3] <= 1'b1;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Main timer
	// ----------------------------------------
	logic [CNT_W-1:0] pos_reg;
	logic [CNT_W-1:0] tm_l_reg;
	logic [DT_W-1:0] dt_l_reg;
	logic [SW_W-1:0] sw_l_reg;
	logic [CNT_W-1:0] duty_l_reg [3];
	logic [SEL_W-1:0] sel_l_reg;
	logic start_w;
	logic wrap_w;
	logic sync_start_w;
	logic load_w;

	assign start_w = ~started_reg & (&written_reg);
	// A zero half period wraps every clock instead of hanging
	assign wrap_w = started_reg &
		(({1'b0, pos_reg} + (CNT_W+1)'(1)) >= {1'b0, tm_l_reg});
	// Period start always, midpoint only in double mode
	assign sync_start_w = wrap_w &
		((half_reg == TPWM_HALF_SECOND) | double_mode_reg);
	assign load_w = start_w | sync_start_w;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			started_reg <= 1'b0;
			half_reg <= TPWM_HALF_FIRST;
			pos_reg <= '0;
		end else if (start_w) begin
			started_reg <= 1'b1;
			// Enter mid-period in double mode, a quarter period in single mode, so the first sync lands on time
			if (double_mode_reg) begin
				half_reg <= TPWM_HALF_SECOND;
				pos_reg <= '0;
			end else begin
				half_reg <= TPWM_HALF_FIRST;
				pos_reg <= half_period_count_reg >> 1;
			end
		end else if (wrap_w) begin
			pos_reg <= '0;
			half_reg <= (half_reg == TPWM_HALF_FIRST) ?
				TPWM_HALF_SECOND : TPWM_HALF_FIRST;
		end else if (started_reg) begin
			pos_reg <= pos_reg + 1'b1;
		end
	end

	// Staged values only move into the timing unit at start and at sync edges
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tm_l_reg <= '0;
			dt_l_reg <= '0;
			sw_l_reg <= `TPWM_SYNC_W_RST;
			duty_l_reg[0] <= '0;
			duty_l_reg[1] <= '0;
			duty_l_reg[2] <= '0;
		end else if (load_w) begin
			tm_l_reg <= half_period_count_reg;
			dt_l_reg <= dead_time_reg;
			sw_l_reg <= sync_pulse_width_reg;
			duty_l_reg[0] <= duty_reg[0];
			duty_l_reg[1] <= duty_reg[1];
			duty_l_reg[2] <= duty_reg[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sel_l_reg <= `TPWM_SEL_RST;
		end else if (load_w) begin
			sel_l_reg <= output_selection_reg;
		end
	end

	// ----------------------------------------
	// Sync pulse
	// ----------------------------------------
	logic [SW_W:0] sync_left_reg;
	logic sync_reg;
	logic irq_reg;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sync_left_reg <= '0;
			sync_reg <= 1'b0;
		end else if (sync_start_w) begin
			sync_left_reg <= {1'b0, sync_pulse_width_reg} + (SW_W+1)'(1);
			sync_reg <= 1'b1;
		end else begin
			if (sync_left_reg != '0)
				sync_left_reg <= sync_left_reg - 1'b1;
			sync_reg <= (sync_left_reg > (SW_W+1)'(1));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			irq_reg <= 1'b0;
		else
			irq_reg <= sync_start_w;
	end

	assign period_sync_pulse = sync_reg;
	assign sync_irq = irq_reg;

	// ----------------------------------------
	// Per-channel timing and output control
	// ----------------------------------------
	logic [2:0] th_w;
	logic [2:0] tl_w;
	tpwm_drive_s drive_next;
	tpwm_drive_s drive_reg;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ch
			localparam int DH = `TPWM_SEG_DIS_BIT + 5 - 2 * gi;
			localparam int DL = `TPWM_SEG_DIS_BIT + 4 - 2 * gi;
			localparam int XO = `TPWM_SEG_XOVER_BIT + 2 - gi;
			logic signed [SW-1:0] p;
			logic signed [SW-1:0] tm;
			logic signed [SW-1:0] du;
			logic signed [SW-1:0] dt;
			logic hi;
			logic lo;
			assign p = $signed({2'b00, pos_reg});
			assign tm = $signed({2'b00, tm_l_reg});
			assign du = $signed({2'b00, duty_l_reg[gi]});
			assign dt = $signed({{(SW-DT_W){1'b0}}, dt_l_reg});
			// Up half ends with the high pulse, down half starts with it;
			// each edge moves out by dt, so the gap per edge is 2*dt
			// Signed compares give 0 and 100 percent limits for free
			always_comb begin
				if (half_reg == TPWM_HALF_FIRST) begin
					hi = p >= tm - du + dt;
					lo = p < tm - du - dt;
				end else begin
					hi = p < du - dt;
					lo = p >= du + dt;
				end
			end
			assign th_w[gi] = hi;
			assign tl_w[gi] = lo;
			assign drive_next.upper[gi] = started_reg & ~sel_l_reg[DH] &
				(sel_l_reg[XO] ? lo : hi);
			assign drive_next.lower[gi] = started_reg & ~sel_l_reg[DL] &
				(sel_l_reg[XO] ? hi : lo);
		end
	endgenerate

	// Gated by start so the drives stay low while idle
	always_ff @(posedge clk_sys) begin
		if (reset)
			drive_reg <= '0;
		else
			drive_reg <= drive_next;
	end

	assign drive = drive_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	logic [SW_W+1:0] hcnt_reg;
	always_ff @(posedge clk_sys) begin
		if (reset)
			hcnt_reg <= '0;
		else if (sync_reg)
			hcnt_reg <= hcnt_reg + 1'b1;
		else
			hcnt_reg <= '0;
	end

	chk_no_overlap: assert property (
		started_reg |-> (th_w & tl_w) == 3'b000)
		else $error("upper and lower overlap");
	chk_dt_zero: assert property (
		started_reg && dt_l_reg == '0 |-> (th_w ^ tl_w) == 3'b111)
		else $error("pair not complementary at zero dead time");
	chk_idle_quiet: assert property (
		!started_reg |=> drive == '0 && !period_sync_pulse)
		else $error("activity before start");
	// Counter still holds the full count in the first low cycle
	chk_sync_width: assert property (
		$fell(period_sync_pulse) |->
			hcnt_reg == {2'b00, sw_l_reg} + (SW_W+2)'(1))
		else $error("sync width wrong");
	chk_mode_reset: assert property (
		$past(reset) |-> !double_mode_reg && !started_reg)
		else $error("mode not single after reset");
	chk_width_reset: assert property (
		$past(reset) |-> sync_pulse_width_reg == `TPWM_SYNC_W_RST)
		else $error("sync width reset value wrong");
	chk_midpoint_sync: assert property (
		$rose(half_reg) && $past(started_reg) &&
			$past(double_mode_reg) |->
			$past(sync_start_w) && period_sync_pulse && sync_irq)
		else $error("no midpoint sync in double mode");
	chk_period_sync: assert property (
		$fell(half_reg) |-> $past(sync_start_w) && period_sync_pulse)
		else $error("no sync at period start");
	chk_latch_sel: assert property (
		sync_start_w |=> sel_l_reg == $past(output_selection_reg))
		else $error("selection not latched at sync");
	chk_start_hold: assert property (
		!(&written_reg) |=> !started_reg)
		else $error("started before all writes");

	cov_start: cover property (start_w);
	cov_double_mid: cover property (
		sync_start_w && half_reg == TPWM_HALF_FIRST);
	cov_dead_gap: cover property (
		started_reg && dt_l_reg != '0 && $fell(th_w[0]));
	cov_bad_addr: cover property (pslverr);

endmodule
